// file: tis_map.vh
// Constants for the trap and interrupt sequencer: register offsets, fields, reset values, levels.
// Assumes a 32-bit APB slave at word-aligned byte offsets.
`ifndef TIS_MAP_VH
`define TIS_MAP_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define TIS_CTRL_OFS 12'h000
`define TIS_STAT_OFS 12'h004
`define TIS_STACK_LIMIT_VALUE_OFS 12'h008
`define TIS_IFLAG_OFS 12'h00c
`define TIS_IEN_OFS 12'h010
`define TIS_IPRIO_OFS 12'h014
`define TIS_SHADOW_OFS 12'h018
// ****************************************
// Fields
// ****************************************
`define TIS_CTRL_ALTV 0
`define TIS_CTRL_MATHEN 1
`define TIS_CTRL_TRAPACK 2
`define TIS_STAT_CONFLICT 15
`define TIS_CTRL_RST 32'h00000000
`define TIS_STACK_LIMIT_VALUE_RST 16'hfffe
`define TIS_STACK_FLOOR 16'h0800
// ****************************************
// Levels and vectors
// ****************************************
`define TIS_LVL_MATH 4'hb
`define TIS_LVL_ADDR 4'hc
`define TIS_LVL_STACK 4'hd
`define TIS_LVL_OSC 4'he
`define TIS_LVL_BLOCK 4'h7
`define TIS_ALT_BASE 8'h80
`define TIS_NUM_IRQ 8
`endif

// file: tis_sequencer.v
// Trap and interrupt sequencer: reset causes, trap detection, interrupt acceptance, context stacking.
// Assumes core event inputs synchronous to pclk, one per instruction cycle; registers over APB.
// Function
// - Reset request on external, watchdog, brownout, uninit pointer, bad opcode, lockout
// - Flushed illegal opcode never raises the bad opcode reset request
// - Traps are unmaskable and wait for the faulting instruction to complete
// - Priority msb set while trap runs, clear during interrupts
// - Level 7 with no trap blocks interrupts but admits traps
// - Divide by zero aborts divide and raises math trap
// - If enabled, overflow from bit 31 without guard bits, or from bit 39 without saturation, raises math trap
// - Oversized shift amount raises math trap
// - Misaligned, unimplemented access or vector-space fetch raises address trap
// - Branch or execution into unimplemented program memory raises address trap
// - Split-space accesses into the other space count as unimplemented
// - Stack pointer above limit or below 0x0800 raises stack trap
// - Oscillator failover raises oscillator trap
// - Math at 11, address 12, stack 13, oscillator 14; fixed priority
// - Hard traps need acknowledge; lower hard trap meanwhile is a conflict
// - Conflict resets device and sets conflict flag bit 15
// - Flags sampled each cycle, gated by enables, then prioritised
// - Interrupt only when priority strictly above current level
// - Accept pushes pc and status byte, loads new level
// - Return pops pc and status byte
// - Alternate select routes every vector to the alternate table
// - Shadow copies written by shadow push, restored by shadow pop only
`default_nettype none
`include "tis_map.vh"
module tis_sequencer (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Reset causes
    input wire ext_reset,
    input wire wdt_timeout,
    input wire brownout_reset,
    input wire uninit_w_ptr,
    input wire illegal_opcode,
    input wire opcode_flushed,
    // Trap causes
    input wire insn_complete,
    input wire div_by_zero,
    input wire acc_ovf31,
    input wire guard_bits_used,
    input wire acc_ovf39,
    input wire saturation_on,
    input wire shift_too_big,
    input wire misaligned_word,
    input wire unimpl_data,
    input wire unimpl_prog,
    input wire vector_fetch,
    input wire mac_class,
    input wire mac_x_in_y,
    input wire mac_y_in_x,
    input wire branch_unimpl,
    input wire pc_unimpl_exec,
    input wire sp_load,
    input wire [15:0] sp_value,
    input wire osc_fail,
    // Interrupt sequencing
    input wire [23:0] pc_in,
    input wire [7:0] status_low_byte,
    input wire return_from_interrupt_op,
    input wire shadow_push,
    input wire shadow_pop,
    input wire [4:0] sr_flags_in,
    input wire [63:0] w03_in,
    input wire [`TIS_NUM_IRQ-1:0] irq_events,
    // Outputs to core
    output reg reset_req,
    output reg div_abort,
    output reg take_exception,
    output reg [7:0] vector_addr,
    output reg [3:0] cpu_priority_level,
    output reg priority_level_msb,
    output reg [23:0] pc_out,
    output reg [7:0] status_out,
    output reg restore_valid,
    output reg [4:0] sr_flags_out,
    output reg [63:0] w03_out
);
// ****************************************
// Registers
// ****************************************
reg alt_vector_select_q, math_en_q, trap_conflict_reset_flag_q;
reg [15:0] stack_limit_value_q;
reg [`TIS_NUM_IRQ-1:0] interrupt_flag_regs_q, interrupt_enable_regs_q;
reg [23:0] iprio_q;
reg [3:0] hard_pend_q;
reg [3:0] soft_pend_q;

// ****************************************
// Context stack
// ****************************************
// Context frames: saved trap level, status byte, pc. The status byte carries only three level
// bits, so the trap level rides along and a nested trap returns into its outer trap intact.
// Sixteen frames; deeper nesting wraps and overwrites the oldest frame.
reg [35:0] stk_pc_q [0:15];
reg [3:0] sp_q;
reg [3:0] level_q;
reg [3:0] trap_lvl_q;
reg trap_act_q;
reg [4:0] shadow_flags_q;
reg [63:0] shadow_w_q;
wire [3:0] top_idx = sp_q - 4'h1;
wire [35:0] top_frame = stk_pc_q[top_idx];
wire [3:0] ret_trap_lvl = top_frame[35:32];
wire wr = psel & penable & pwrite;
wire rd_acc = psel & ~pwrite;

function [3:0] top_hard;
    input [3:0] p;
    begin
        top_hard = p[2] ? `TIS_LVL_OSC : p[1] ? `TIS_LVL_STACK : p[0] ? `TIS_LVL_ADDR : 4'h0;
    end
endfunction

// ****************************************
// Trap detection
// ****************************************
// Pending traps are held until taken (soft) or acknowledged by software (hard)
wire math_c = div_by_zero | shift_too_big
    | (math_en_q & ((acc_ovf31 & ~guard_bits_used) | (acc_ovf39 & ~saturation_on)));
wire mac_bad = mac_class & (mac_x_in_y | mac_y_in_x);
wire addr_c = misaligned_word | unimpl_data | unimpl_prog | vector_fetch
    | mac_bad | branch_unimpl | pc_unimpl_exec;
wire stack_c = sp_load & ((sp_value > stack_limit_value_q) | (sp_value < `TIS_STACK_FLOOR));
wire [2:0] hard_new = {osc_fail, stack_c, addr_c};
wire [3:0] held_top = top_hard({1'b0, hard_pend_q[2:0]});
wire [3:0] cur_hard = (trap_act_q && trap_lvl_q >= `TIS_LVL_ADDR) ? trap_lvl_q : 4'h0;
wire [3:0] block_lvl = (held_top > cur_hard) ? held_top : cur_hard;

// ****************************************
// Lockout detection
// ****************************************
// A lower hard trap arriving under a higher pending or running one cannot be nested safely
reg conflict;
integer k;
always @* begin
    conflict = 1'b0;
    for (k = 0; k < 3; k = k + 1) begin
        if (hard_new[k] && block_lvl > (`TIS_LVL_ADDR + k[3:0])) begin
            conflict = 1'b1;
        end
    end
    // Simultaneous address and stack faults lock out at once
    if (hard_new[0] & hard_new[1]) begin
        conflict = 1'b1;
    end
end

// ****************************************
// Reset causes
// ****************************************
// Lockout shares the reset path so a conflict ends all sequencing at once
wire illegal_ok = illegal_opcode & ~opcode_flushed;
wire rst_now = ext_reset | wdt_timeout | brownout_reset | uninit_w_ptr | illegal_ok | conflict;

// ****************************************
// Interrupt selection
// ****************************************
reg [3:0] best_lvl;
reg [2:0] best_idx;
reg [2:0] pr;
integer i;
always @* begin
    best_lvl = 4'h0;
    best_idx = 3'h0;
    pr = 3'h0;
    for (i = `TIS_NUM_IRQ - 1; i >= 0; i = i - 1) begin
        pr = iprio_q[3*i +: 3];
        if (interrupt_flag_regs_q[i] && interrupt_enable_regs_q[i] && {1'b0, pr} >= best_lvl && pr != 3'h0) begin
            best_lvl = {1'b0, pr};
            best_idx = i[2:0];
        end
    end
end
wire [3:0] pend_trap = hard_pend_q[2:0] != 3'h0 ? top_hard({1'b0, hard_pend_q[2:0]})
    : (soft_pend_q[0] ? `TIS_LVL_MATH : 4'h0);
wire trap_go = insn_complete && pend_trap > level_q && pend_trap > trap_lvl_q;
// Level 7 blocks every request because request priorities are only three bits wide
wire irq_go = insn_complete && !trap_go && !trap_act_q && best_lvl > level_q;
wire [7:0] base = alt_vector_select_q ? `TIS_ALT_BASE : 8'h00;

// ****************************************
// Sequencing
// ****************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        reset_req <= 1'b0;
        div_abort <= 1'b0;
        take_exception <= 1'b0;
        vector_addr <= 8'h00;
        cpu_priority_level <= 4'h0;
        priority_level_msb <= 1'b0;
        pc_out <= 24'h000000;
        status_out <= 8'h00;
        restore_valid <= 1'b0;
        sr_flags_out <= 5'h00;
        w03_out <= 64'h0;
        hard_pend_q <= 4'h0;
        soft_pend_q <= 4'h0;
        sp_q <= 4'h0;
        level_q <= 4'h0;
        trap_lvl_q <= 4'h0;
        trap_act_q <= 1'b0;
        shadow_flags_q <= 5'h00;
        shadow_w_q <= 64'h0;
        interrupt_flag_regs_q <= 8'h00;
        trap_conflict_reset_flag_q <= 1'b0;
    end else begin
        reset_req <= rst_now;
        div_abort <= div_by_zero;
        take_exception <= 1'b0;
        restore_valid <= 1'b0;
        // Set wins over a software clear in the same cycle
        interrupt_flag_regs_q <= ((wr && paddr == `TIS_IFLAG_OFS) ? pwdata[7:0] : interrupt_flag_regs_q)
            | irq_events;
        if (conflict) begin
            trap_conflict_reset_flag_q <= 1'b1;
        end else if (wr && paddr == `TIS_STAT_OFS && pwdata[`TIS_STAT_CONFLICT]) begin
            trap_conflict_reset_flag_q <= 1'b0;
        end
        if (rst_now) begin
            hard_pend_q <= 4'h0;
            soft_pend_q <= 4'h0;
            trap_act_q <= 1'b0;
            trap_lvl_q <= 4'h0;
            level_q <= 4'h0;
            sp_q <= 4'h0;
        end else begin
            hard_pend_q <= hard_pend_q | {1'b0, hard_new};
            soft_pend_q[0] <= soft_pend_q[0] | math_c;
            // Vector and level are registered with the take pulse; the level reaches the core a cycle later
            if (trap_go) begin
                stk_pc_q[sp_q] <= {trap_lvl_q, status_low_byte, pc_in};
                sp_q <= sp_q + 4'h1;
                trap_act_q <= 1'b1;
                trap_lvl_q <= pend_trap;
                level_q <= pend_trap;
                take_exception <= 1'b1;
                vector_addr <= base | {4'h0, pend_trap};
                if (pend_trap == `TIS_LVL_MATH) begin
                    soft_pend_q[0] <= math_c;
                end
            end else if (irq_go) begin
                stk_pc_q[sp_q] <= {trap_lvl_q, status_low_byte, pc_in};
                sp_q <= sp_q + 4'h1;
                level_q <= best_lvl;
                take_exception <= 1'b1;
                vector_addr <= base | (8'h08 + {5'h00, best_idx});
            end else if (return_from_interrupt_op && sp_q != 4'h0) begin
                pc_out <= top_frame[23:0];
                status_out <= top_frame[31:24];
                restore_valid <= 1'b1;
                sp_q <= sp_q - 4'h1;
                // Returning into an outer trap keeps the msb set
                if (ret_trap_lvl != 4'h0) begin
                    level_q <= ret_trap_lvl;
                    trap_act_q <= 1'b1;
                    trap_lvl_q <= ret_trap_lvl;
                end else begin
                    level_q <= {1'b0, top_frame[31:29]};
                    trap_act_q <= 1'b0;
                    trap_lvl_q <= 4'h0;
                end
            end
            // Software acknowledges hard traps; until then the trap stays pending in hard_pend_q, so a lower hard trap is a conflict
            if (wr && paddr == `TIS_CTRL_OFS && pwdata[`TIS_CTRL_TRAPACK]) begin
                hard_pend_q <= {1'b0, hard_new};
            end
        end
        cpu_priority_level <= level_q;
        priority_level_msb <= trap_act_q;
        // ****************************************
        // Shadow context
        // ****************************************
        // One level deep: a nested push overwrites the outer copy
        if (shadow_push) begin
            shadow_flags_q <= sr_flags_in;
            shadow_w_q <= w03_in;
        end
        if (shadow_pop) begin
            sr_flags_out <= shadow_flags_q;
            w03_out <= shadow_w_q;
        end
    end
end

// ****************************************
// APB slave, zero wait states
// ****************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        alt_vector_select_q <= 1'b0;
        math_en_q <= 1'b0;
        stack_limit_value_q <= `TIS_STACK_LIMIT_VALUE_RST;
        interrupt_enable_regs_q <= 8'h00;
        iprio_q <= 24'h924924;
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & ~penable;
        pslverr <= 1'b0;
        if (wr) begin
            case (paddr)
                `TIS_CTRL_OFS: begin
                    alt_vector_select_q <= pwdata[`TIS_CTRL_ALTV];
                    math_en_q <= pwdata[`TIS_CTRL_MATHEN];
                end
                `TIS_STACK_LIMIT_VALUE_OFS: stack_limit_value_q <= pwdata[15:0];
                `TIS_IEN_OFS: interrupt_enable_regs_q <= pwdata[7:0];
                `TIS_IPRIO_OFS: iprio_q <= pwdata[23:0];
                default: ;
            endcase
        end
        // Read data is captured in the setup cycle so it stands with pready
        // Unmapped reads return zero; no error response is ever given
        if (rd_acc && !penable) begin
            case (paddr)
                `TIS_CTRL_OFS: prdata <= {30'h0, math_en_q, alt_vector_select_q};
                `TIS_STAT_OFS: prdata <= {16'h0, trap_conflict_reset_flag_q, 3'h0, trap_act_q, hard_pend_q[2:0],
                    soft_pend_q[0], 3'h0, level_q};
                `TIS_STACK_LIMIT_VALUE_OFS: prdata <= {16'h0, stack_limit_value_q};
                `TIS_IFLAG_OFS: prdata <= {24'h0, interrupt_flag_regs_q};
                `TIS_IEN_OFS: prdata <= {24'h0, interrupt_enable_regs_q};
                `TIS_IPRIO_OFS: prdata <= {8'h0, iprio_q};
                `TIS_SHADOW_OFS: prdata <= {27'h0, shadow_flags_q};
                default: prdata <= 32'h0;
            endcase
        end
    end
end
endmodule // tis_sequencer
`default_nettype wire

// file: tis_seq_chk_assertions.sv
// Port checker for the trap and interrupt sequencer.
// Assumes one pclk domain with asynchronous active-low presetn.
`default_nettype none
module tis_seq_chk (
    // Clock, reset and bus
    input wire logic pclk, presetn, psel, penable, pready, pslverr,
    // Core side
    input wire logic ext_reset, wdt_timeout, brownout_reset, uninit_w_ptr, reset_req, div_by_zero, div_abort,
    input wire logic insn_complete, take_exception, priority_level_msb, return_from_interrupt_op, restore_valid,
    input wire logic shadow_pop,
    input wire logic [3:0] cpu_priority_level,
    input wire logic [4:0] sr_flags_out,
    input wire logic [63:0] w03_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Steps of bus and shadow traffic
    // ****************************************
    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable && pready; endsequence
    // Two quiet cycles, so a late shadow update is not taken for a stray one
    sequence quiet_s; !shadow_pop ##1 !shadow_pop; endsequence
    bus_answer_a: assert property (setup_s |=> pready)
        else $error("no answer to setup");
    ready_pulse_a: assert property (access_s |=> !pready)
        else $error("ready held too long");
    no_slverr_a: assert property (!pslverr)
        else $error("error response seen");
    reset_cause_a: assert property ((ext_reset || wdt_timeout || brownout_reset || uninit_w_ptr) |=> reset_req)
        else $error("reset cause ignored");
    div_abort_a: assert property (div_by_zero |=> div_abort)
        else $error("divide not aborted");
    abort_cause_a: assert property (div_abort |-> $past(div_by_zero))
        else $error("abort without cause");
    take_retire_a: assert property (take_exception |-> $past(insn_complete))
        else $error("exception before retire");
    msb_level_a: assert property (priority_level_msb == cpu_priority_level[3])
        else $error("msb disagrees with level");
    restore_cause_a: assert property (restore_valid |-> $past(return_from_interrupt_op))
        else $error("restore without return");
    shadow_hold_a: assert property (quiet_s |=> $stable(sr_flags_out) && $stable(w03_out))
        else $error("shadow changed without pop");
endmodule // tis_seq_chk
bind tis_sequencer tis_seq_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .ext_reset, .wdt_timeout,
    .brownout_reset, .uninit_w_ptr, .reset_req, .div_by_zero, .div_abort, .insn_complete, .take_exception,
    .priority_level_msb, .return_from_interrupt_op, .restore_valid, .shadow_pop, .cpu_priority_level,
    .sr_flags_out, .w03_out);
`default_nettype wire

// file: tis_core_model.sv
// Core pipeline stand-in: retires instructions, reports pc and status byte.
// Assumes the sequencer's registered take_exception and level outputs.
`default_nettype none
module tis_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // From sequencer
    input wire logic take_exception,
    input wire logic [3:0] cpu_priority_level,
    // To sequencer
    output logic insn_complete,
    output logic [23:0] pc_in,
    output logic [7:0] status_low_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_q;
    // One stall slot in four, and none while vectoring, so traps wait for retire
    assign insn_complete = presetn && (cnt_q != 2'b11) && !take_exception;
    assign status_low_byte = {cpu_priority_level[2:0], 5'h00};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'b00;
            pc_in <= 24'h000100;
        end else begin
            cnt_q <= cnt_q + 2'b01;
            if (insn_complete) pc_in <= pc_in + 24'h000002;
        end
    end
endmodule // tis_core_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the trap and interrupt sequencer.
// Assumes the sequencer, the core model and the bound checker are compiled.
`default_nettype none
`include "tis_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, insn_complete, reset_req, div_abort, take_exception, priority_level_msb, restore_valid;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, cv, seed = 32'h000019e5;
    logic [25:0] ev = 26'h0;
    logic [7:0] irq_v = 8'h00, vector_addr, status_low_byte, status_out;
    logic [15:0] sp_v = 16'h0000, spl;
    logic [63:0] wv = 64'h0, w03_out, ew;
    logic [4:0] fv = 5'h00, sr_flags_out;
    logic [3:0] cpu_priority_level;
    logic [23:0] pc_in, pc_out;
    logic [25:0] tm [13];
    logic [23:0] pstk [16];
    int pn = 0;
    logic [7:0] tv [13];
    int error_cnt = 0, total_checks = 0;
    always #25 pclk = ~pclk;
    tis_core_model core (.pclk, .presetn, .take_exception, .cpu_priority_level, .insn_complete, .pc_in,
        .status_low_byte);
    tis_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_reset(ev[0]), .wdt_timeout(ev[1]), .brownout_reset(ev[2]), .uninit_w_ptr(ev[3]),
        .illegal_opcode(ev[4]), .opcode_flushed(ev[5]), .insn_complete, .div_by_zero(ev[6]), .acc_ovf31(ev[7]),
        .guard_bits_used(ev[8]), .acc_ovf39(ev[9]), .saturation_on(ev[10]), .shift_too_big(ev[11]),
        .misaligned_word(ev[12]), .unimpl_data(ev[13]), .unimpl_prog(ev[14]), .vector_fetch(ev[15]),
        .mac_class(ev[16]), .mac_x_in_y(ev[17]), .mac_y_in_x(ev[18]), .branch_unimpl(ev[19]),
        .pc_unimpl_exec(ev[20]), .sp_load(ev[21]), .sp_value(sp_v), .osc_fail(ev[22]), .pc_in, .status_low_byte,
        .return_from_interrupt_op(ev[23]), .shadow_push(ev[24]), .shadow_pop(ev[25]), .sr_flags_in(fv),
        .w03_in(wv), .irq_events(irq_v), .reset_req, .div_abort, .take_exception, .vector_addr,
        .cpu_priority_level, .priority_level_msb, .pc_out, .status_out, .restore_valid, .sr_flags_out, .w03_out);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Ends mid-cycle after the edge that sampled the pulse
    task automatic pulse(input logic [25:0] m, input logic [7:0] q);
        @(posedge pclk);
        ev <= m;
        irq_v <= q;
        @(posedge pclk);
        ev <= 26'h0;
        irq_v <= 8'h00;
        @(negedge pclk);
    endtask
    task automatic ex(input logic [7:0] v, input logic [3:0] l);
        int n;
        n = 0;
        while (take_exception !== 1'b1 && n < 20) begin
            @(negedge pclk);
            n++;
        end
        chk(take_exception, 1'b1);
        pstk[pn] = pc_in - 24'h000002;
        pn++;
        @(negedge pclk);
        chk(vector_addr, v);
        @(negedge pclk);
        chk({priority_level_msb, cpu_priority_level}, {l[3], l});
    endtask
    task automatic quiet();
        logic s;
        s = 1'b0;
        repeat (8) begin
            @(negedge pclk);
            if (take_exception === 1'b1) s = 1'b1;
        end
        chk(s, 1'b0);
    endtask
    task automatic ret(input logic [7:0] s);
        pulse(26'h0800000, 8'h00);
        pn--;
        chk({restore_valid, status_out, pc_out}, {1'b1, s, pstk[pn]});
    endtask
    task automatic trap(input logic [25:0] m, input logic [7:0] v, input logic [7:0] s);
        pulse(m, 8'h00);
        ex(v, v[3:0]);
        if (v[3:2] == 2'b11) apb(1'b1, `TIS_CTRL_OFS, cv | 32'h4);
        ret(s);
    endtask
    initial begin
        #500000;
        error_cnt++;
        complete_run();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        tm = '{26'h40, 26'h800, 26'h80, 26'h200, 26'h1000, 26'h2000, 26'h4000, 26'h8000, 26'h80000, 26'h100000,
            26'h30000, 26'h50000, 26'h200000};
        tv = '{8'h0b, 8'h0b, 8'h0b, 8'h0b, 8'h8c, 8'h8c, 8'h8c, 8'h8c, 8'h8c, 8'h8c, 8'h8c, 8'h8c, 8'h8d};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `TIS_STACK_LIMIT_VALUE_OFS, 32'h0);
        chk(rd, {16'h0, `TIS_STACK_LIMIT_VALUE_RST});
        apb(1'b0, `TIS_CTRL_OFS, 32'h0);
        chk(rd, `TIS_CTRL_RST);
        apb(1'b0, 12'h100, 32'hffffffff);
        chk(rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            pulse(26'h1 << i, 8'h00);
            chk(reset_req, 1'b1);
        end
        pulse(26'h30, 8'h00);
        chk(reset_req, 1'b0);
        rd = xs();
        spl = 16'h0800 | {2'b00, rd[13:1], 1'b0};
        apb(1'b1, `TIS_STACK_LIMIT_VALUE_OFS, {16'h0, spl});
        apb(1'b0, `TIS_STACK_LIMIT_VALUE_OFS, 32'h0);
        chk(rd, {16'h0, spl});
        sp_v <= spl + 16'h0002;
        cv = 32'h2;
        apb(1'b1, `TIS_CTRL_OFS, cv);
        for (int i = 0; i < 13; i++) begin
            if (i == 4) cv = 32'h3;
            if (i == 4) apb(1'b1, `TIS_CTRL_OFS, cv);
            trap(tm[i], tv[i], 8'h00);
        end
        apb(1'b1, `TIS_IEN_OFS, 32'h5);
        apb(1'b1, `TIS_IPRIO_OFS, 32'h1c4);
        pulse(26'h0, 8'h02);
        quiet();
        apb(1'b1, `TIS_IFLAG_OFS, 32'h0);
        pulse(26'h0, 8'h01);
        ex(8'h88, 4'h4);
        apb(1'b1, `TIS_IFLAG_OFS, 32'h0);
        pulse(26'h0, 8'h04);
        ex(8'h8a, 4'h7);
        apb(1'b1, `TIS_IFLAG_OFS, 32'h0);
        pulse(26'h0, 8'h01);
        quiet();
        apb(1'b1, `TIS_IFLAG_OFS, 32'h0);
        trap(26'h400000, 8'h8e, 8'he0);
        ret(8'h80);
        ret(8'h00);
        ew = {xs(), xs()};
        fv <= ew[4:0];
        wv <= ew;
        pulse(26'h1000000, 8'h00);
        @(posedge pclk);
        wv <= ~ew;
        fv <= ~ew[4:0];
        pulse(26'h2000000, 8'h00);
        @(negedge pclk);
        chk({sr_flags_out, w03_out}, {ew[4:0], ew});
        sp_v <= 16'h07fe;
        pulse(26'h201000, 8'h00);
        chk(reset_req, 1'b1);
        apb(1'b0, `TIS_STAT_OFS, 32'h0);
        chk(rd[`TIS_STAT_CONFLICT], 1'b1);
        apb(1'b1, `TIS_STAT_OFS, 32'h8000);
        apb(1'b0, `TIS_STAT_OFS, 32'h0);
        chk(rd[`TIS_STAT_CONFLICT], 1'b0);
        complete_run();
    end
endmodule // tb
`default_nettype wire
